// File: design/cfg_access_consts.svh
/*
 Fixed numbers of the configuration-access mechanism: I/O locations,
 address-register field positions, reset values and AD encodings.
 Assumes it is included by bare name from each design file that needs it.
*/
`ifndef CFG_ACCESS_CONSTS_SVH
`define CFG_ACCESS_CONSTS_SVH

// host I/O locations and access widths
`define CFG_ADDR_PORT 16'h0CF8
`define CFG_DATA_PORT 16'h0CFC
`define CFG_FULL_BE 4'hF

// address register fields
`define CFG_ENABLE_BIT 31
`define CFG_BUS_MSB 23
`define CFG_BUS_LSB 16
`define CFG_DEV_MSB 15
`define CFG_DEV_LSB 11
`define CFG_FUNCTION_NUMBER_FIELD_MSB 10
`define CFG_FUNCTION_NUMBER_FIELD_LSB 8
`define CFG_REG_MSB 7
`define CFG_REG_LSB 2
`define CFG_ADDR_WR_MASK 32'h80FFFFFC

// reset values and the all-ones read value of the disabled window
`define CFG_ADDR_RESET 32'h00000000
`define CFG_DATA_RESET 32'h00000000
`define CFG_ALL_ONES 32'hFFFFFFFF

// PCI address phase encodings
`define CFG_TYPE0_CODE 2'h0
`define CFG_TYPE1_CODE 2'h1
`define CFG_DEV_LIMIT 20
`define CFG_IDSEL_LSB 11
`define CFG_IDSEL_BITS 21
`define CFG_TYPE1_PAD 8'h00

// own configuration space
`define CFG_NUM_FUNCS 3'h3
`define CFG_ID_DWORD 6'h00
`define CFG_HDR_LAST_DW 6'h0F

`endif

// File: design/cfg_access_pkg.sv
/*
 Types of the configuration-access mechanism: sequencer states and the
 packed state record of the top module.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cfg_access_pkg;

   typedef enum logic [1:0] {ST_IDLE, ST_MEM_RD, ST_PCI_WAIT} cfg_state_t;

   typedef struct packed {
      cfg_state_t st;
      logic [31:0] addr;
      logic [31:0] data;
      logic [31:0] rdata;
      logic ack;
      logic fwd;
      logic start;
      logic [31:0] ad;
      logic wr;
      logic [31:0] wdata;
      logic [3:0] be;
   } cfg_regs_t;

endpackage

// File: design/cfg_space_mem.sv
/*
 Byte-writable storage for the bridge's own configuration functions.
 Assumes one clock; read data are registered and follow rd_addr one edge late.
*/
`timescale 1ns/1ps
module cfg_space_mem #(
   parameter int AW = 8,
   parameter int BYTES = 4
) (
   // clock
   input wire logic ref_clk,
   // write side
   input wire logic we,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [BYTES-1:0] wr_be,
   input wire logic [8*BYTES-1:0] wr_data,
   // read side
   input wire logic [AW-1:0] rd_addr,
   output logic [8*BYTES-1:0] rd_data
);

   if (AW < 1 || BYTES < 1) begin : g_chk
      $error("cfg_space_mem: bad geometry");
   end

   logic [8*BYTES-1:0] mem [0:(1<<AW)-1];

   // all byte lanes in one process: a write address that is not constant
   // makes the whole array the written prefix, so one writer only
   always_ff @(posedge ref_clk) begin
      for (int gb = 0; gb < BYTES; gb++) begin
         if (we && wr_be[gb]) begin
            mem[wr_addr][8*gb +: 8] <= wr_data[8*gb +: 8];
         end
      end
   end

   // contents are not reset; software initialises what it uses
   always_ff @(posedge ref_clk) begin
      rd_data <= mem[rd_addr];
   end

endmodule

// File: design/pci_config_access_mechanism.sv
/*
 Host-side configuration access of a host-to-PCI bridge: address register,
 data window, own configuration functions and PCI config-cycle issue.
 Assumes host I/O requests are one-cycle pulses made only while no answer is
 pending, and that the PCI engine outside runs the cycle and pulses cfg_done.
*/
`timescale 1ns/1ps
`include "cfg_access_consts.svh"

//////////////////////////////////////////////////////////////////////////////

// Operation
// - type 0 cycles decode device number into one AD31..11 select line.
// - bridge is device 0, answered inside; AD11 never raised.
// - device 20 is highest decodable, selecting AD31.
// - device above 20 still runs type 0 with no select line.
// - type 1 cycles carry device number on AD15..11 unchanged.
// - function number goes unchanged onto AD10..8.
// - bridge claims its own accesses only for its own function numbers.
// - bus 0 device 0 foreign function goes out type 0, no select.
// - register number goes unchanged onto AD7..2.
// - data window at 0CFC, 32 bits, read/write, resets to zero.
// - window accesses target the register the address register selects.
// - config accesses happen only while the enable bit is set.
// - own space holds standard header 00..3F, device functions above.
// - three own functions: bridge, memory controller, scratch pad.
// - address register loads only on dword access; others pass to PCI.
// - bus zero gives type 0 or internal; nonzero gives type 1 with bus.
// - bit 31 of the address register is the configuration enable.
module pci_config_access_mechanism #(
   parameter logic [15:0] VENDOR_CODE = 16'hA5A5, // arbitrary value
   parameter logic [15:0] PART_CODE = 16'h5A01, // arbitrary value
   parameter int DEV_MAX = `CFG_DEV_LIMIT
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // host I/O port
   input wire logic io_req,
   input wire logic io_wr,
   input wire logic [15:0] io_addr,
   input wire logic [3:0] io_be,
   input wire logic [31:0] io_wdata,
   output logic io_ack,
   output logic io_fwd,
   output logic [31:0] io_rdata,
   // PCI configuration cycle engine
   output logic cfg_start,
   output logic [31:0] cfg_ad,
   output logic cfg_wr,
   output logic [31:0] cfg_wdata,
   output logic [3:0] cfg_be,
   input wire logic cfg_done,
   input wire logic [31:0] cfg_rdata
);

   if (DEV_MAX < 1 || DEV_MAX > `CFG_DEV_LIMIT) begin : g_chk
      $error("pci_config_access_mechanism: DEV_MAX out of range");
   end

   cfg_access_pkg::cfg_regs_t cur_r;
   cfg_access_pkg::cfg_regs_t cur_nxt;

   //////////////////////////////////////////////////////////////////////////
   // address register decode

   logic cfg_en;
   logic [7:0] bus_num;
   logic [4:0] device_number_field;
   logic [2:0] function_number_field;
   logic [5:0] reg_num;
   logic internal_hit;
   logic id_hit;
   logic [`CFG_IDSEL_BITS-1:0] idsel;
   logic [31:0] ad_type0;
   logic [31:0] ad_type1;
   logic [31:0] ad_calc;

   assign cfg_en = cur_r.addr[`CFG_ENABLE_BIT];
   assign bus_num = cur_r.addr[`CFG_BUS_MSB:`CFG_BUS_LSB];
   assign device_number_field = cur_r.addr[`CFG_DEV_MSB:`CFG_DEV_LSB];
   assign function_number_field = cur_r.addr[`CFG_FUNCTION_NUMBER_FIELD_MSB:`CFG_FUNCTION_NUMBER_FIELD_LSB];
   assign reg_num = cur_r.addr[`CFG_REG_MSB:`CFG_REG_LSB];

   // own functions 0..2 on bus 0 device 0 stay inside the bridge
   assign internal_hit = (bus_num == 8'h00) && (device_number_field == 5'h00)
      && (function_number_field < `CFG_NUM_FUNCS);
   // identity dword of function 0 is read-only
   assign id_hit = (function_number_field == 3'h0) && (reg_num == `CFG_ID_DWORD);

   // device 0 never selects: its only outgoing cycles are foreign functions
   assign idsel[0] = 1'b0;
   for (genvar gi = 1; gi < `CFG_IDSEL_BITS; gi++) begin : g_idsel
      // values above DEV_MAX match no bit, so no target is selected
      assign idsel[gi] = (device_number_field == 5'(gi)) && (gi <= DEV_MAX);
   end

   assign ad_type0 = {idsel, function_number_field, reg_num, `CFG_TYPE0_CODE};
   assign ad_type1 = {`CFG_TYPE1_PAD, bus_num, device_number_field,
      function_number_field, reg_num, `CFG_TYPE1_CODE};
   assign ad_calc = (bus_num == 8'h00) ? ad_type0 : ad_type1;

   //////////////////////////////////////////////////////////////////////////
   // own configuration space

   logic mem_we;
   logic [31:0] mem_rdata;
   logic [7:0] mem_idx;

   // 64 dwords per function: header 00..3F first, device registers above
   assign mem_idx = {function_number_field[1:0], reg_num};

   cfg_space_mem #(
      .AW(8),
      .BYTES(4)
   ) u_space (
      .ref_clk(ref_clk),
      .we(mem_we),
      .wr_addr(mem_idx),
      .wr_be(io_be),
      .wr_data(io_wdata),
      .rd_addr(mem_idx),
      .rd_data(mem_rdata)
   );

   //////////////////////////////////////////////////////////////////////////
   // sequencer next state

   always_comb begin
      cur_nxt = cur_r;
      cur_nxt.ack = 1'b0;
      cur_nxt.fwd = 1'b0;
      cur_nxt.start = 1'b0;
      mem_we = 1'b0;
      case (cur_r.st)
         cfg_access_pkg::ST_IDLE: begin
            if (io_req) begin
               if (io_addr == `CFG_ADDR_PORT && io_be == `CFG_FULL_BE) begin
                  // reserved bits are dropped so they read back zero
                  if (io_wr) begin
                     cur_nxt.addr = io_wdata & `CFG_ADDR_WR_MASK;
                  end else begin
                     cur_nxt.rdata = cur_r.addr;
                  end
                  cur_nxt.ack = 1'b1;
               end else if (io_addr == `CFG_DATA_PORT) begin
                  if (!cfg_en) begin
                     // disabled window: write dropped, read floats high
                     cur_nxt.ack = 1'b1;
                     if (!io_wr) begin
                        cur_nxt.rdata = `CFG_ALL_ONES;
                     end
                  end else if (internal_hit) begin
                     if (io_wr) begin
                        mem_we = !id_hit;
                        cur_nxt.data = io_wdata;
                        cur_nxt.ack = 1'b1;
                     end else begin
                        cur_nxt.st = cfg_access_pkg::ST_MEM_RD;
                     end
                  end else begin
                     cur_nxt.start = 1'b1;
                     cur_nxt.ad = ad_calc;
                     cur_nxt.wr = io_wr;
                     cur_nxt.wdata = io_wdata;
                     cur_nxt.be = io_be;
                     if (io_wr) begin
                        cur_nxt.data = io_wdata;
                     end
                     cur_nxt.st = cfg_access_pkg::ST_PCI_WAIT;
                  end
               end else begin
                  // partial access at 0CF8 and every other port go to PCI as I/O
                  cur_nxt.fwd = 1'b1;
               end
            end
         end
         cfg_access_pkg::ST_MEM_RD: begin
            cur_nxt.data = id_hit ? {PART_CODE, VENDOR_CODE} : mem_rdata;
            cur_nxt.rdata = cur_nxt.data;
            cur_nxt.ack = 1'b1;
            cur_nxt.st = cfg_access_pkg::ST_IDLE;
         end
         cfg_access_pkg::ST_PCI_WAIT: begin
            if (cfg_done) begin
               if (!cur_r.wr) begin
                  cur_nxt.data = cfg_rdata;
                  cur_nxt.rdata = cfg_rdata;
               end
               cur_nxt.ack = 1'b1;
               cur_nxt.st = cfg_access_pkg::ST_IDLE;
            end
         end
         default: begin
            cur_nxt.st = cfg_access_pkg::ST_IDLE;
         end
      endcase
   end

   // whole state record; data window and address register reset to zero
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cur_r <= '0;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   // outputs straight from the record
   assign io_ack = cur_r.ack;
   assign io_fwd = cur_r.fwd;
   assign io_rdata = cur_r.rdata;
   assign cfg_start = cur_r.start;
   assign cfg_ad = cur_r.ad;
   assign cfg_wr = cur_r.wr;
   assign cfg_wdata = cur_r.wdata;
   assign cfg_be = cur_r.be;

   //////////////////////////////////////////////////////////////////////////
   // checks

   AST_ONE_SELECT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg_start && cfg_ad[1:0] == `CFG_TYPE0_CODE |-> $countones(cfg_ad[31:11]) <= 1)
      else $error("more than one select line in type 0 cycle");

   AST_NO_AD11: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg_start && cfg_ad[1:0] == `CFG_TYPE0_CODE |-> !cfg_ad[`CFG_IDSEL_LSB])
      else $error("AD11 raised in type 0 cycle");

   AST_DEV_SELECT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg_start && cfg_ad[1:0] == `CFG_TYPE0_CODE && device_number_field != 5'h00
      && device_number_field <= DEV_MAX |-> cfg_ad[`CFG_IDSEL_LSB + device_number_field])
      else $error("wrong select line for device number");

   AST_HIGH_DEV: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg_start && cfg_ad[1:0] == `CFG_TYPE0_CODE && device_number_field > DEV_MAX
      |-> cfg_ad[31:11] == 21'h000000)
      else $error("select line raised for device above 20");

   AST_FIELDS: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg_start |-> cfg_ad[10:2] == cur_r.addr[10:2])
      else $error("function or register field not copied");

   AST_TYPE1: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg_start && bus_num != 8'h00 |-> cfg_ad[1:0] == `CFG_TYPE1_CODE
      && cfg_ad[23:11] == cur_r.addr[23:11])
      else $error("type 1 address phase wrong");

   AST_ENABLED: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(cfg_start) |-> $past(cfg_en))
      else $error("config cycle issued while disabled");

   AST_OWN_KEPT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg_start |-> !internal_hit)
      else $error("own function forwarded to PCI");

   AST_PARTIAL_ADDR: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cur_r.st == cfg_access_pkg::ST_IDLE && io_req && io_addr == `CFG_ADDR_PORT
      && io_be != `CFG_FULL_BE |=> io_fwd && cur_r.addr == $past(cur_r.addr))
      else $error("partial access changed address register");

   AST_OWN_READ: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cur_r.st == cfg_access_pkg::ST_IDLE && io_req && !io_wr && io_addr == `CFG_DATA_PORT
      && cfg_en && internal_hit |=> !io_ack ##1 io_ack)
      else $error("internal window read not answered in two cycles");

endmodule

// File: sim/pci_cfg_engine_model.sv
/*
 Behavioural PCI configuration-cycle engine facing the access block.
 Assumes one outstanding cycle; lat sets the extra wait before cfg_done.
*/
`timescale 1ns/1ps
module pci_cfg_engine_model #(
   parameter logic [31:0] RD_MASK = 32'h5A5A0F0F
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // cycle request side
   input wire logic cfg_start,
   input wire logic [31:0] cfg_ad,
   input wire logic [3:0] lat,
   // answer side
   output logic cfg_done,
   output logic [31:0] cfg_rdata
);
   logic busy = 1'b0;
   logic [3:0] cnt = 4'h0;
   //////////////////////////////////////////////////////////////////////////
   // read data toggle outside done so a stale value never looks valid
   always @(posedge ref_clk) begin
      cfg_done <= 1'b0;
      cfg_rdata <= ~cfg_rdata;
      if (sys_rst) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         cfg_rdata <= 32'h00000000;
      end else if (cfg_start) begin
         busy <= 1'b1;
         cnt <= lat;
      end else if (busy) begin
         if (cnt == 4'h0) begin
            cfg_done <= 1'b1;
            cfg_rdata <= cfg_ad ^ RD_MASK;
            busy <= 1'b0;
         end else begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule

// File: sim/testbench.sv
/*
 Self-checking bench of the configuration-access block with engine model.
 Assumes the model answers read data as cfg_ad xor its read mask.
*/
`timescale 1ns/1ps
module testbench;
   localparam logic [15:0] VC = 16'hC3C3; // arbitrary value
   localparam logic [15:0] PC = 16'h3C07; // arbitrary value
   localparam logic [31:0] RM = 32'h5A5A0F0F;
   localparam logic [33:0] ACKN = 34'h100000000;
   localparam logic [33:0] FWD = 34'h200000000;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic io_req = 1'b0;
   logic io_wr = 1'b0;
   logic [15:0] io_addr = 16'h0000;
   logic [3:0] io_be = 4'h0;
   logic [3:0] lat = 4'h0;
   logic [31:0] io_wdata = 32'h00000000;
   logic io_ack, io_fwd, cfg_start, cfg_wr, cfg_done;
   logic [31:0] io_rdata, cfg_ad, cfg_wdata, cfg_rdata, a, d;
   logic [3:0] cfg_be;
   logic [34:0] ans_q[$];
   logic [68:0] ad_q[$];
   int failures = 0;
   int comparisons = 0;
   int seed = 61215;
   pci_config_access_mechanism #(.VENDOR_CODE(VC), .PART_CODE(PC)) pci_config_access_mechanism_i (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .io_req(io_req), .io_wr(io_wr),
      .io_addr(io_addr), .io_be(io_be), .io_wdata(io_wdata), .io_ack(io_ack),
      .io_fwd(io_fwd), .io_rdata(io_rdata), .cfg_start(cfg_start), .cfg_ad(cfg_ad),
      .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_done(cfg_done),
      .cfg_rdata(cfg_rdata));
   pci_cfg_engine_model #(.RD_MASK(RM)) pci_cfg_engine_model_i (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .cfg_start(cfg_start), .cfg_ad(cfg_ad), .lat(lat),
      .cfg_done(cfg_done), .cfg_rdata(cfg_rdata));
   //////////////////////////////////////////////////////////////////////////
   // clock, watchdog, verdict
   initial forever #5 ref_clk = ~ref_clk;
   initial begin
      #400000;
      failures++;
      give_verdict();
   end
   task automatic give_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////
   // compare tasks and expected address phase
   // bit 34 marks a read: io_rdata only changes on read answers
   task automatic compare_ans(input logic [34:0] e);
      comparisons++;
      if ({io_fwd, io_ack} !== e[33:32] || (e[34] && e[32] && e[31:0] !== io_rdata)) begin
         failures++;
         $display("wrong value io answer expected %h seen %h", e, {io_fwd, io_ack, io_rdata});
      end
   endtask
   task automatic compare_ad(input logic [68:0] e);
      comparisons++;
      if ({cfg_wr, cfg_be, cfg_ad} !== {e[68:64], e[31:0]} || (e[68] && cfg_wdata !== e[63:32]))
      begin
         failures++;
         $display("wrong value cfg cycle expected %h seen %h", e,
                  {cfg_wr, cfg_be, cfg_wdata, cfg_ad});
      end
   endtask
   function automatic logic [31:0] exp_ad(input logic [31:0] x);
      logic [31:0] sel;
      sel = 32'h00000000;
      if (x[23:16] != 8'h00) return {8'h00, x[23:2], 2'h1};
      if (x[15:11] >= 5'h01 && x[15:11] <= 5'h14) sel[11 + x[15:11]] = 1'b1;
      return {sel[31:11], x[10:2], 2'h0};
   endfunction
   //////////////////////////////////////////////////////////////////////////
   // host driver: one-cycle request, then bounded wait for the answer
   task automatic io_op(input logic wr, input logic [15:0] ad, input logic [3:0] be,
                        input logic [31:0] wd, input logic [33:0] e);
      int n;
      ans_q.push_back({~wr, e});
      @(posedge ref_clk);
      io_req <= 1'b1;
      io_wr <= wr;
      io_addr <= ad;
      io_be <= be;
      io_wdata <= wd;
      @(posedge ref_clk);
      io_req <= 1'b0;
      n = 0;
      while (!(io_ack === 1'b1 || io_fwd === 1'b1) && n < 60) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 60) begin
         failures++;
         $display("wrong value io answer expected answer seen none");
      end
   endtask
   // window access that must reach the engine; enable set by host first
   task automatic win(input logic wr, input logic [31:0] x, input logic [31:0] wd);
      logic [3:0] be;
      be = 4'($random(seed)) | 4'h1;
      lat <= 4'($random(seed));
      io_op(1'b1, 16'h0CF8, 4'hF, x, ACKN);
      ad_q.push_back({wr, be, wd, exp_ad(x)});
      io_op(wr, 16'h0CFC, be, wd, wr ? ACKN : {2'h1, exp_ad(x) ^ RM});
   endtask
   //////////////////////////////////////////////////////////////////////////
   // monitor: every answer and every cycle start consumes the oldest note
   always @(posedge ref_clk) begin
      if (io_ack === 1'b1 || io_fwd === 1'b1) begin
         if (ans_q.size() == 0) begin
            failures++;
            $display("wrong value io answer expected none seen %h", io_rdata);
         end else compare_ans(ans_q.pop_front());
      end
      if (cfg_start === 1'b1) begin
         if (ad_q.size() == 0) begin
            failures++;
            $display("wrong value cfg cycle expected none seen %h", cfg_ad);
         end else compare_ad(ad_q.pop_front());
      end
   end
   //////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      io_op(1'b0, 16'h0CF8, 4'hF, 32'h0, {2'h1, 32'h0});
      io_op(1'b0, 16'h0CFC, 4'hF, 32'h0, {2'h1, 32'hFFFFFFFF});
      io_op(1'b1, 16'h0CFC, 4'hF, 32'h12345678, ACKN);
      io_op(1'b1, 16'h0CF8, 4'h3, 32'h80000800, FWD);
      io_op(1'b0, 16'h0080, 4'hF, 32'h0, FWD);
      io_op(1'b1, 16'h0CF8, 4'hF, 32'hFFFFFFFF, ACKN);
      io_op(1'b0, 16'h0CF8, 4'hF, 32'h0, {2'h1, 32'h80FFFFFC});
      $display("test reset, disable and address register done");
      for (int dv = 0; dv < 32; dv++) begin
         a = {1'b1, 15'h0000, 5'(dv), 3'($random(seed)), 6'($random(seed)), 2'h0};
         if (dv == 0) a[10:8] = 3'h3 + 3'(($random(seed) & 32'h7) % 5);
         win(1'($random(seed)), a, $random(seed));
      end
      for (int k = 0; k < 8; k++) begin
         a = {8'h80, 8'($random(seed) | 1), 14'($random(seed)), 2'h0};
         win(1'($random(seed)), a, $random(seed));
      end
      $display("test pci config cycles done");
      for (int f = 0; f < 3; f++) begin
         a = {16'h8000, 5'h00, 3'(f), 6'h10 + 6'(f), 2'h0};
         d = $random(seed);
         io_op(1'b1, 16'h0CF8, 4'hF, a, ACKN);
         io_op(1'b1, 16'h0CFC, 4'hF, d, ACKN);
         io_op(1'b1, 16'h0CFC, 4'h1, ~d, ACKN);
         io_op(1'b0, 16'h0CFC, 4'hF, 32'h0, {2'h1, d[31:8], ~d[7:0]});
      end
      io_op(1'b1, 16'h0CF8, 4'hF, 32'h80000000, ACKN);
      io_op(1'b1, 16'h0CFC, 4'hF, 32'h0, ACKN);
      io_op(1'b0, 16'h0CFC, 4'hF, 32'h0, {2'h1, PC, VC});
      $display("test own functions done");
      // let the monitor take the last answer before judging
      @(negedge ref_clk);
      if (ans_q.size() != 0 || ad_q.size() != 0) begin
         failures++;
         $display("wrong value notes left expected 0 seen %0d", ans_q.size() + ad_q.size());
      end
      give_verdict();
   end
endmodule
